// ===== bench/wdr_top_tb_top.sv
`timescale 1ns/1ps
module wdr_top_tb_top;
  // ==========================================================
  // bench signals
  localparam int P = 8;
  localparam int RC = wdr_pkg::RST_CYCLES;
  logic sys_clk_i = 1'b0;
  logic rst_n_i;
  logic sfr_wr_i;
  logic [7:0] sfr_addr_i;
  logic [7:0] sfr_wdata_i;
  logic [7:0] sfr_rdata_o;
  logic power_down_i;
  logic dog_irq_enable_i;
  logic irq_o;
  logic [15:0] irq_vector_o;
  logic [3:0] irq_priority_o;
  logic wdt_rst_o;
  int err_total = 0;
  int samples_checked = 0;
  logic [15:0] rd_q[$];
  int rst_q[$];
  logic rd_req = 1'b0;
  logic rd_d1 = 1'b0;
  int hi_cnt = 0;

  // ==========================================================
  // design under test
  wdr_top #(.PRESC_CYCLES(P), .RST_CYCLES(RC)) i_wdr_top (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .sfr_wr_i(sfr_wr_i),
    .sfr_addr_i(sfr_addr_i),
    .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o),
    .power_down_i(power_down_i),
    .dog_irq_enable_i(dog_irq_enable_i),
    .irq_o(irq_o),
    .irq_vector_o(irq_vector_o),
    .irq_priority_o(irq_priority_o),
    .wdt_rst_o(wdt_rst_o)
  );

  initial begin
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  // ==========================================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out;
    $display("checks=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    sfr_wr_i <= 1'b1;
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    @(posedge sys_clk_i);
    sfr_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    @(posedge sys_clk_i);
    sfr_addr_i <= a;
    rd_req <= 1'b1;
    rd_q.push_back({m, e});
    @(posedge sys_clk_i);
    rd_req <= 1'b0;
    @(posedge sys_clk_i);
  endtask : rd

  task automatic feed(input logic [7:0] d);
    wr(wdr_pkg::ADDR_KEY_FIRST, wdr_pkg::KEY_FIRST_VAL);
    wr(wdr_pkg::ADDR_KEY_SECOND, wdr_pkg::KEY_SECOND_VAL);
    wr(wdr_pkg::ADDR_CTRL, d);
  endtask : feed

  task automatic wait_rst;
    int i;
    for (i = 0; i < 3000 && wdt_rst_o !== 1'b1; i++) cyc(1);
    for (i = 0; i < 400 && wdt_rst_o !== 1'b0; i++) cyc(1);
    cyc(2);
  endtask : wait_rst

  // ==========================================================
  // monitors
  always @(posedge sys_clk_i) begin
    logic [15:0] n;
    if (rd_d1) begin
      n = rd_q.pop_front();
      check(sfr_rdata_o & n[15:8], n[7:0]);
    end
    rd_d1 <= rd_req;
  end

  always @(posedge sys_clk_i) begin
    if (wdt_rst_o === 1'b1) begin
      hi_cnt <= hi_cnt + 1;
    end else if (hi_cnt != 0) begin
      if (rst_q.size() == 0) check(hi_cnt, 0);
      else check(hi_cnt, rst_q.pop_front());
      hi_cnt <= 0;
    end
  end

  initial begin
    cyc(20000);
    err_total++;
    close_out();
  end

  // ==========================================================
  // stimulus
  initial begin
    logic [7:0] r;
    rst_n_i = 1'b0;
    sfr_wr_i = 1'b0;
    sfr_addr_i = 8'h00;
    sfr_wdata_i = 8'h00;
    power_down_i = 1'b0;
    dog_irq_enable_i = 1'b0;
    r = 8'($urandom(32'h1846a36a));
    cyc(3);
    rst_n_i <= 1'b1;
    rd(wdr_pkg::ADDR_CTRL, 8'h00);
    rd(wdr_pkg::ADDR_RELOAD, 8'h00);
    rd(wdr_pkg::ADDR_COUNT, 8'h00);
    check(irq_vector_o, 16'h0053);
    check(irq_priority_o, 4'h9);
    wr(8'h90, r);
    rd(8'h90, 8'h00);
    // timer mode counting
    r = 8'($urandom_range(8'hF0));
    wr(wdr_pkg::ADDR_RELOAD, r);
    wr(wdr_pkg::ADDR_CTRL, 8'h03);
    rd(wdr_pkg::ADDR_COUNT, r);
    cyc(4 * P);
    rd(wdr_pkg::ADDR_COUNT, r + 8'h04);
    wr(wdr_pkg::ADDR_CTRL, 8'h02);
    cyc(5 * P);
    rd(wdr_pkg::ADDR_COUNT, r);
    power_down_i <= 1'b1;
    wr(wdr_pkg::ADDR_CTRL, 8'h03);
    cyc(5 * P);
    rd(wdr_pkg::ADDR_COUNT, r);
    wr(wdr_pkg::ADDR_CTRL, 8'h00);
    power_down_i <= 1'b0;
    // overflow, flag and interrupt
    wr(wdr_pkg::ADDR_RELOAD, 8'hFD);
    wr(wdr_pkg::ADDR_CTRL, 8'h03);
    cyc(3 * P);
    rd(wdr_pkg::ADDR_CTRL, 8'h05);
    check(irq_o, 1'b0);
    dog_irq_enable_i <= 1'b1;
    cyc(1);
    check(irq_o, 1'b1);
    wr(wdr_pkg::ADDR_CTRL, 8'h00);
    wr(wdr_pkg::ADDR_CTRL, 8'h04);
    rd(wdr_pkg::ADDR_CTRL, 8'h00);
    check(irq_o, 1'b0);
    // force run held until overflow
    wr(wdr_pkg::ADDR_RELOAD, 8'h00);
    wr(wdr_pkg::ADDR_CTRL, 8'h42);
    wr(wdr_pkg::ADDR_CTRL, 8'h00);
    rd(wdr_pkg::ADDR_CTRL, 8'h40);
    cyc(256 * P);
    rd(wdr_pkg::ADDR_CTRL, 8'h44);
    wr(wdr_pkg::ADDR_CTRL, 8'h04);
    rd(wdr_pkg::ADDR_CTRL, 8'h00);
    dog_irq_enable_i <= 1'b0;
    // watchdog mode keys
    wr(wdr_pkg::ADDR_CTRL, 8'h08);
    rd(wdr_pkg::ADDR_CTRL, 8'h08);
    wr(wdr_pkg::ADDR_CTRL, 8'h00);
    rd(wdr_pkg::ADDR_CTRL, 8'h08);
    feed(8'h00);
    rd(wdr_pkg::ADDR_CTRL, 8'h08);
    wr(wdr_pkg::ADDR_RELOAD, 8'hFD);
    repeat (6) begin
      feed(8'h0B);
      cyc(2);
    end
    feed(8'h08);
    rd(wdr_pkg::ADDR_CTRL, 8'h08);
    // overflow without refresh
    wr(wdr_pkg::ADDR_RELOAD, 8'h00);
    rst_q.push_back(RC);
    feed(8'h0B);
    wait_rst();
    rd(wdr_pkg::ADDR_CTRL, 8'h0C, 8'h0C);
    wr(wdr_pkg::ADDR_CTRL, 8'h04);
    rd(wdr_pkg::ADDR_CTRL, 8'h04, 8'h04);
    feed(8'h0C);
    rd(wdr_pkg::ADDR_CTRL, 8'h08, 8'h0F);
    // wrong second key, then stray write as third
    rst_q.push_back(RC);
    wr(wdr_pkg::ADDR_KEY_FIRST, wdr_pkg::KEY_FIRST_VAL);
    wr(wdr_pkg::ADDR_KEY_SECOND, 8'($urandom_range(8'h29)));
    wait_rst();
    rst_q.push_back(RC);
    wr(wdr_pkg::ADDR_KEY_FIRST, wdr_pkg::KEY_FIRST_VAL);
    wr(wdr_pkg::ADDR_KEY_SECOND, wdr_pkg::KEY_SECOND_VAL);
    wr(wdr_pkg::ADDR_RELOAD, 8'h00);
    wait_rst();
    rd(wdr_pkg::ADDR_CTRL, 8'h08, 8'h0B);
    // power-on reset with the counter stopped clears reset enable and flag
    rst_n_i <= 1'b0;
    cyc(3);
    rst_n_i <= 1'b1;
    rd(wdr_pkg::ADDR_CTRL, 8'h00);
    cyc(5);
    check(rst_q.size(), 0);
    check(rd_q.size(), 0);
    close_out();
  end
endmodule : wdr_top_tb_top

// ===== verilog/wdr_ctl_if.sv
`timescale 1ns/1ps
interface wdr_ctl_if;
  logic presc_clr;
  logic presc_run;
  logic tick;
  logic rst_req;
  logic rst_busy;

  modport core (
    output presc_clr,
    output presc_run,
    output rst_req,
    input tick,
    input rst_busy
  );
  modport presc (
    input presc_clr,
    input presc_run,
    output tick
  );
  modport strch (
    input rst_req,
    output rst_busy
  );
endinterface : wdr_ctl_if

// ===== verilog/wdr_pkg.sv
package wdr_pkg;

  // ==========================================================
  // special function register addresses
  localparam logic [7:0] ADDR_CTRL = 8'h91;
  localparam logic [7:0] ADDR_RELOAD = 8'h92;
  localparam logic [7:0] ADDR_KEY_FIRST = 8'h93;
  localparam logic [7:0] ADDR_KEY_SECOND = 8'h94;
  localparam logic [7:0] ADDR_COUNT = 8'h95;

  // ==========================================================
  // feed key values
  localparam logic [7:0] KEY_FIRST_VAL = 8'hFD;
  localparam logic [7:0] KEY_SECOND_VAL = 8'h2A;

  // ==========================================================
  // dog_control bit positions
  localparam int CTRL_FORCE = 6;
  localparam int CTRL_RSTEN = 3;
  localparam int CTRL_FLAG = 2;
  localparam int CTRL_REFRESH = 1;
  localparam int CTRL_RUN = 0;

  // ==========================================================
  // reset values
  localparam logic [7:0] RELOAD_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // ==========================================================
  // timing and counter limits
  localparam int PRESC_CYCLES = 344064;
  localparam int RST_CYCLES = 196;
  localparam logic [7:0] COUNT_TERM = 8'hFE;

  // ==========================================================
  // interrupt identity
  localparam logic [15:0] IRQ_VECTOR = 16'h0053;
  localparam logic [3:0] IRQ_PRIORITY = 4'h9;

  // ==========================================================
  // feed sequence states
  typedef enum logic [1:0] {
    WDR_KEY_IDLE = 2'b00,
    WDR_KEY_ONE = 2'b01,
    WDR_KEY_TWO = 2'b11
  } wdr_key_e;

endpackage : wdr_pkg

// ===== verilog/wdr_prescaler.sv
`timescale 1ns/1ps
module wdr_prescaler #(
  parameter int PRESC_CYCLES = wdr_pkg::PRESC_CYCLES
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // control
  wdr_ctl_if.presc ctl
);
  localparam int PW = $clog2(PRESC_CYCLES);
  localparam logic [PW-1:0] LAST = PW'(PRESC_CYCLES - 1);
  localparam logic [PW-1:0] ZERO = '0;
  localparam logic [PW-1:0] ONE = PW'(1);

  logic [PW-1:0] cnt_q;
  logic [PW-1:0] cnt_d;

  // ==========================================================
  // divider
  assign ctl.tick = ctl.presc_run && !ctl.presc_clr && (cnt_q == LAST);

  always_comb begin
    cnt_d = cnt_q;
    if (ctl.presc_clr) begin
      cnt_d = ZERO;
    end else if (ctl.presc_run) begin
      cnt_d = (cnt_q == LAST) ? ZERO : cnt_q + ONE;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ==========================================================
  // checks
  AST_PRESC_CLEAR: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ctl.presc_clr |=> cnt_q == ZERO)
    else $error("prescaler not cleared");
  AST_PRESC_TICK: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ctl.tick |=> cnt_q == ZERO ##0 (!ctl.tick))
    else $error("prescaler tick spacing wrong");

endmodule : wdr_prescaler

// ===== verilog/wdr_reset_stretch.sv
`timescale 1ns/1ps
module wdr_reset_stretch #(
  parameter int RST_CYCLES = wdr_pkg::RST_CYCLES
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // control
  wdr_ctl_if.strch ctl
);
  localparam int CW = $clog2(RST_CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(RST_CYCLES - 1);
  localparam logic [CW-1:0] ZERO = '0;
  localparam logic [CW-1:0] ONE = CW'(1);

  logic busy_q;
  logic busy_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [8:0] hi_len_q;

  // ==========================================================
  // pulse stretcher
  assign ctl.rst_busy = busy_q;

  always_comb begin
    busy_d = busy_q;
    cnt_d = cnt_q;
    if (ctl.rst_req) begin
      busy_d = 1'b1;
      cnt_d = LOAD;
    end else if (busy_q) begin
      if (cnt_q == ZERO) begin
        busy_d = 1'b0;
      end else begin
        cnt_d = cnt_q - ONE;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      busy_q <= busy_d;
      cnt_q <= cnt_d;
    end
  end

  // ==========================================================
  // checks
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hi_len_q <= '0;
    end else if (busy_q) begin
      hi_len_q <= (hi_len_q == 9'h1FF) ? hi_len_q : hi_len_q + 9'h001;
    end else begin
      hi_len_q <= '0;
    end
  end

  AST_RST_WIDTH: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $fell(busy_q) |-> $past(hi_len_q) >= 9'(RST_CYCLES - 1))
    else $error("reset pulse too short");

endmodule : wdr_reset_stretch

// ===== verilog/wdr_top.sv
`timescale 1ns/1ps
module wdr_top #(
  parameter int PRESC_CYCLES = wdr_pkg::PRESC_CYCLES,
  parameter int RST_CYCLES = wdr_pkg::RST_CYCLES
) (
  // clock and power-on reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // special function register port
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // power and interrupt enable
  input wire logic power_down_i,
  input wire logic dog_irq_enable_i,
  // interrupt request
  output logic irq_o,
  output logic [15:0] irq_vector_o,
  output logic [3:0] irq_priority_o,
  // watchdog reset
  output logic wdt_rst_o
);

  // ==========================================================
  // state
  wdr_pkg::wdr_key_e key_q;
  wdr_pkg::wdr_key_e key_d;
  logic rsten_q;
  logic rsten_d;
  logic force_q;
  logic force_d;
  logic lock_q;
  logic lock_d;
  logic run_q;
  logic run_d;
  logic flag_q;
  logic flag_d;
  logic [7:0] reload_q;
  logic [7:0] reload_d;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  logic wr_ctrl;
  logic wr_reload;
  logic wr_key1;
  logic wr_key2;
  logic key_bad;
  logic ctrl_we;
  logic refresh;
  logic counting;
  logic ovf;

  wdr_ctl_if ctl ();

  // ==========================================================
  // address decode
  function automatic logic hit(input logic wr, input logic [7:0] addr, input logic [7:0] reg_addr);
    hit = wr && (addr == reg_addr);
  endfunction : hit

  assign wr_ctrl = hit(sfr_wr_i, sfr_addr_i, wdr_pkg::ADDR_CTRL);
  assign wr_reload = hit(sfr_wr_i, sfr_addr_i, wdr_pkg::ADDR_RELOAD);
  assign wr_key1 = hit(sfr_wr_i, sfr_addr_i, wdr_pkg::ADDR_KEY_FIRST);
  assign wr_key2 = hit(sfr_wr_i, sfr_addr_i, wdr_pkg::ADDR_KEY_SECOND);

  // ==========================================================
  // feed sequence
  always_comb begin
    key_d = key_q;
    key_bad = 1'b0;
    unique case (key_q)
      wdr_pkg::WDR_KEY_IDLE: begin
        if (rsten_q && wr_key1 && sfr_wdata_i == wdr_pkg::KEY_FIRST_VAL) begin
          key_d = wdr_pkg::WDR_KEY_ONE;
        end
      end
      wdr_pkg::WDR_KEY_ONE: begin
        if (wr_key2 && sfr_wdata_i == wdr_pkg::KEY_SECOND_VAL) begin
          key_d = wdr_pkg::WDR_KEY_TWO;
        end else if (sfr_wr_i) begin
          key_d = wdr_pkg::WDR_KEY_IDLE;
          key_bad = 1'b1;
        end
      end
      wdr_pkg::WDR_KEY_TWO: begin
        if (wr_ctrl) begin
          key_d = wdr_pkg::WDR_KEY_IDLE;
        end else if (sfr_wr_i) begin
          key_d = wdr_pkg::WDR_KEY_IDLE;
          key_bad = 1'b1;
        end
      end
      default: begin
        key_d = wdr_pkg::WDR_KEY_IDLE;
      end
    endcase
    if (ctl.rst_busy || !rsten_q) begin
      key_d = wdr_pkg::WDR_KEY_IDLE;
    end
  end

  // control writes: free in timer mode, keyed in watchdog mode
  assign ctrl_we = wr_ctrl && (!rsten_q || key_q == wdr_pkg::WDR_KEY_TWO);
  assign refresh = ctrl_we && sfr_wdata_i[wdr_pkg::CTRL_REFRESH];

  // ==========================================================
  // control register
  always_comb begin
    rsten_d = rsten_q | (ctrl_we & sfr_wdata_i[wdr_pkg::CTRL_RSTEN]);
    lock_d = lock_q;
    force_d = force_q;
    run_d = run_q;
    flag_d = flag_q;
    if (ovf) begin
      lock_d = 1'b0;
    end
    if (ctrl_we) begin
      run_d = sfr_wdata_i[wdr_pkg::CTRL_RUN];
      force_d = sfr_wdata_i[wdr_pkg::CTRL_FORCE] | (lock_q & ~ovf);
      if (sfr_wdata_i[wdr_pkg::CTRL_FORCE]) begin
        lock_d = 1'b1;
      end
      if (sfr_wdata_i[wdr_pkg::CTRL_FLAG]) begin
        flag_d = 1'b0;
      end
    end
    if (ovf) begin
      flag_d = 1'b1;
    end
  end

  // ==========================================================
  // counter
  assign counting = (force_q | run_q) & ~power_down_i & ~ctl.rst_busy;
  assign ovf = ctl.tick && (cnt_q >= wdr_pkg::COUNT_TERM);

  assign ctl.presc_run = counting;
  assign ctl.presc_clr = refresh | ctl.rst_busy;
  assign ctl.rst_req = key_bad | (ovf & rsten_q);

  always_comb begin
    reload_d = reload_q;
    cnt_d = cnt_q;
    if (wr_reload) begin
      reload_d = sfr_wdata_i;
    end
    if (refresh || ctl.rst_busy) begin
      cnt_d = reload_q;
    end else if (ctl.tick) begin
      cnt_d = ovf ? reload_q : cnt_q + 8'h01;
    end
  end

  // ==========================================================
  // read data
  always_comb begin
    rdata_d = 8'h00;
    unique case (sfr_addr_i)
      wdr_pkg::ADDR_CTRL: begin
        rdata_d[wdr_pkg::CTRL_FORCE] = force_q;
        rdata_d[wdr_pkg::CTRL_RSTEN] = rsten_q;
        rdata_d[wdr_pkg::CTRL_FLAG] = flag_q;
        rdata_d[wdr_pkg::CTRL_RUN] = run_q;
      end
      wdr_pkg::ADDR_RELOAD: begin
        rdata_d = reload_q;
      end
      wdr_pkg::ADDR_COUNT: begin
        rdata_d = cnt_q;
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      key_q <= wdr_pkg::WDR_KEY_IDLE;
      rsten_q <= 1'b0;
      force_q <= 1'b0;
      lock_q <= 1'b0;
      run_q <= 1'b0;
      flag_q <= 1'b0;
      reload_q <= wdr_pkg::RELOAD_RST;
      cnt_q <= wdr_pkg::COUNT_RST;
      rdata_q <= wdr_pkg::RDATA_RST;
    end else begin
      key_q <= key_d;
      rsten_q <= rsten_d;
      force_q <= force_d;
      lock_q <= lock_d;
      run_q <= run_d;
      flag_q <= flag_d;
      reload_q <= reload_d;
      cnt_q <= cnt_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // outputs
  assign sfr_rdata_o = rdata_q;
  assign irq_o = flag_q & dog_irq_enable_i & ~rsten_q;
  assign irq_vector_o = wdr_pkg::IRQ_VECTOR;
  assign irq_priority_o = wdr_pkg::IRQ_PRIORITY;
  assign wdt_rst_o = ctl.rst_busy;

  // ==========================================================
  // submodules
  wdr_prescaler #(
    .PRESC_CYCLES(PRESC_CYCLES)
  ) u_presc (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .ctl(ctl.presc)
  );

  wdr_reset_stretch #(
    .RST_CYCLES(RST_CYCLES)
  ) u_strch (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .ctl(ctl.strch)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_REFRESH_LOAD: assert property (
    refresh && !ctl.rst_busy |=> cnt_q == $past(reload_q))
    else $error("refresh did not load counter");
  AST_OVF_FLAG: assert property (
    ovf |=> flag_q)
    else $error("overflow did not set flag");
  AST_WD_RESET: assert property (
    ovf && rsten_q |=> wdt_rst_o [*8])
    else $error("watchdog overflow gave no reset");
  AST_KEY_BAD: assert property (
    key_bad |=> wdt_rst_o)
    else $error("bad feed gave no reset");
  AST_TIMER_RELOAD: assert property (
    ovf && !rsten_q && !refresh |=> cnt_q == $past(reload_q) && flag_q && !wdt_rst_o)
    else $error("timer overflow did not reload");
  AST_IRQ_GATE: assert property (
    irq_o |-> dog_irq_enable_i && flag_q && !rsten_q)
    else $error("interrupt raised while gated");
  AST_CTRL_GUARD: assert property (
    rsten_q && wr_ctrl && key_q != wdr_pkg::WDR_KEY_TWO |=> run_q == $past(run_q))
    else $error("unkeyed control write took effect");
  AST_RSTEN_STICKY: assert property (
    rsten_q |=> rsten_q)
    else $error("reset enable cleared");
  AST_FORCE_HOLD: assert property (
    lock_q && !ovf |=> force_q)
    else $error("force run released early");
  AST_TIMER_FREE: assert property (
    !rsten_q && wr_ctrl |=> run_q == $past(sfr_wdata_i[wdr_pkg::CTRL_RUN]))
    else $error("timer mode control write ignored");
  AST_PD_HALT: assert property (
    power_down_i && !refresh && !ctl.rst_busy |=> cnt_q == $past(cnt_q))
    else $error("counter moved in power-down");
  AST_IRQ_ON: assert property (
    ovf && !rsten_q && !wr_ctrl |=> irq_o == dog_irq_enable_i)
    else $error("timer overflow interrupt not gated by enable");
  AST_CNT_IDLE: assert property (
    !ctl.tick && !refresh && !ctl.rst_busy |=> cnt_q == $past(cnt_q))
    else $error("counter moved without a prescaler tick");
  AST_FLAG_HOLD: assert property (
    flag_q && !ctrl_we |=> flag_q)
    else $error("overflow flag cleared without a write");

  COV_TIMER_OVF: cover property (ovf && !rsten_q);
  COV_WD_RESET: cover property (ovf && rsten_q);
  COV_FEED_OK: cover property (key_q == wdr_pkg::WDR_KEY_TWO && wr_ctrl);
  COV_FEED_BAD: cover property (key_bad);
  COV_FORCE_OVF: cover property (lock_q && ovf);

endmodule : wdr_top
